// ==== src/dcc_top.sv ====
// calibration control register block with apb slave and interrupt
//
// What this block does
// - setting launch bit 0 starts calibration of each paged converter.
// - status bit 2 reads 1 while calibration runs; resets to 0.
// - status bit 1 set when calibration fails.
// - status bit 0 set once calibration completes.
// - mode, launch, status and full-scale are per converter, chosen by page.
// - eight-bit full-scale code per converter, resets to 0x28, read-write.
// - ring oscillator divider 00..11 selects 8, 16, 32, 64; resets to 2.
// - reference control bit 6 selects reference input coupling, resets 0.
`timescale 1ns/1ps
`include "dcc_defs.svh"
module dcc_top
    import dcc_pkg::*;
#(
    parameter int NUM_CONV   = 2,
    parameter int CAL_CYCLES = `DCC_CAL_CYCLES
) (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    // apb slave
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [11:0]        i_paddr,
    input  wire logic [31:0]        i_pwdata,
    output logic      [31:0]        o_prdata,
    output logic                    o_pready,
    output logic                    o_pslverr,
    // converter controls
    output dcc_pkg::dcc_byte_t      o_full_scale_code_conv0,
    output dcc_pkg::dcc_byte_t      o_full_scale_code_conv1,
    output logic [6:0]              o_ring_osc_ratio,
    output logic                    o_reference_coupling_select,
    output logic [1:0]              o_cal_clock_off,
    // interrupt
    output logic                    o_irq
);
    import dcc_pkg::*;

    logic [NUM_CONV-1:0] active, fail, done;
    logic [NUM_CONV-1:0] start_pulse;
    dcc_byte_t           page_r, page_nxt;
    dcc_byte_t           clk_div_r, clk_div_nxt;
    dcc_byte_t           tune_r, tune_nxt;
    dcc_byte_t           clk_pd_r, clk_pd_nxt;
    logic                eng_en_r, eng_en_nxt;
    logic [1:0]          ring_r, ring_nxt;
    logic                ref_r, ref_nxt;
    logic [1:0]          mode_r [NUM_CONV];
    logic [1:0]          mode_nxt [NUM_CONV];
    dcc_byte_t           fsc_r [NUM_CONV];
    dcc_byte_t           fsc_nxt [NUM_CONV];
    logic [3:0]          irq_stat_r, irq_stat_nxt;
    logic [3:0]          irq_mask_r, irq_mask_nxt;
    logic [NUM_CONV-1:0] done_d_r, fail_d_r;
    logic [31:0]         prdata_r, prdata_nxt;
    logic                wr_acc, rd_acc;
    logic                busy, setup_ok;
    logic [11:0]         idx;

    assign idx    = {2'b00, i_paddr[11:2]};
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign rd_acc = i_psel && i_penable && !i_pwrite;
    assign busy   = |active;
    assign setup_ok = eng_en_r && (clk_div_r[3:0] == `DCC_OPT_CLK_DIV);

    // one engine per converter
    genvar g;
    generate
        for (g = 0; g < NUM_CONV; g++) begin : g_conv
            assign start_pulse[g] = wr_acc && (idx == `DCC_IDX_CTRL) && (page_r[g])
                && i_pwdata[`DCC_BIT_START] && !active[g];
            dcc_cal_engine #(
                .CAL_CYCLES (CAL_CYCLES)
            ) u_engine (
                .i_clk      (i_clk),
                .i_sys_rst  (i_sys_rst),
                .i_start    (start_pulse[g]),
                .i_setup_ok (setup_ok && (mode_r[g] == `DCC_OPT_MODE)),
                .i_clk_off  (clk_pd_r[g]),
                .o_active   (active[g]),
                .o_fail     (fail[g]),
                .o_done     (done[g])
            );
        end
    endgenerate

    // register writes
    always_comb begin
        page_nxt    = page_r;
        clk_div_nxt = clk_div_r;
        tune_nxt    = tune_r;
        clk_pd_nxt  = clk_pd_r;
        eng_en_nxt  = eng_en_r;
        ring_nxt    = ring_r;
        ref_nxt     = ref_r;
        irq_mask_nxt = irq_mask_r;
        for (int k = 0; k < NUM_CONV; k++) begin
            mode_nxt[k] = mode_r[k];
            fsc_nxt[k]  = fsc_r[k];
        end
        if (wr_acc) begin
            case (idx)
                `DCC_IDX_PAGE:     page_nxt = i_pwdata[7:0];
                `DCC_IDX_CLK_DIV:  clk_div_nxt = i_pwdata[7:0];
                `DCC_IDX_TUNE:     tune_nxt = i_pwdata[7:0];
                `DCC_IDX_CLK_PD:   clk_pd_nxt = {6'h00, i_pwdata[1:0]};
                `DCC_IDX_RING:     ring_nxt = i_pwdata[1:0];
                `DCC_IDX_SYSREF:   ref_nxt = i_pwdata[`DCC_BIT_REF_MODE];
                `DCC_IDX_IRQ_MASK: irq_mask_nxt = i_pwdata[3:0];
                `DCC_IDX_CTRL: begin
                    eng_en_nxt = i_pwdata[`DCC_BIT_ENGINE_EN];
                    for (int k = 0; k < NUM_CONV; k++) begin
                        if (page_r[k]) begin
                            mode_nxt[k] = i_pwdata[2:1];
                        end
                    end
                end
                `DCC_IDX_FSC: begin
                    for (int k = 0; k < NUM_CONV; k++) begin
                        if (page_r[k]) begin
                            fsc_nxt[k] = i_pwdata[7:0];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // interrupt status: rising done/fail per converter, set wins over clear
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (wr_acc && idx == `DCC_IDX_IRQ_STAT) begin
            irq_stat_nxt = irq_stat_r & ~i_pwdata[3:0];
        end
        for (int k = 0; k < NUM_CONV; k++) begin
            if (done[k] && !done_d_r[k]) begin
                irq_stat_nxt[k] = 1'b1;
            end
            if (fail[k] && !fail_d_r[k]) begin
                irq_stat_nxt[k+2] = 1'b1;
            end
        end
    end

    // read data, from the first paged converter
    always_comb begin
        int sel;
        sel = 0;
        for (int k = NUM_CONV - 1; k >= 0; k--) begin
            if (page_r[k]) begin
                sel = k;
            end
        end
        prdata_nxt = prdata_r;
        if (i_psel && !i_penable && !i_pwrite) begin
            prdata_nxt = 32'h0;
            case (idx)
                `DCC_IDX_PAGE:     prdata_nxt[7:0] = page_r;
                `DCC_IDX_CLK_DIV:  prdata_nxt[7:0] = clk_div_r;
                `DCC_IDX_CTRL:     prdata_nxt[7:0] = {eng_en_r, 4'h0, mode_r[sel], 1'b0};
                `DCC_IDX_STAT:     prdata_nxt[7:0] = {5'h00, active[sel],
                                                      fail[sel], done[sel]};
                `DCC_IDX_FSC:      prdata_nxt[7:0] = fsc_r[sel];
                `DCC_IDX_TUNE:     prdata_nxt[7:0] = tune_r;
                `DCC_IDX_CLK_PD:   prdata_nxt[7:0] = clk_pd_r;
                `DCC_IDX_RING:     prdata_nxt[7:0] = {6'h00, ring_r};
                `DCC_IDX_SYSREF:   prdata_nxt[7:0] = {1'b0, ref_r, 6'h00};
                `DCC_IDX_IRQ_STAT: prdata_nxt[3:0] = irq_stat_r;
                `DCC_IDX_IRQ_MASK: prdata_nxt[3:0] = irq_mask_r;
                default:           prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            page_r     <= `DCC_RST_PAGE;
            clk_div_r  <= `DCC_RST_CLK_DIV;
            tune_r     <= `DCC_RST_TUNE;
            clk_pd_r   <= 8'h00;
            eng_en_r   <= `DCC_RST_ENGINE_EN;
            ring_r     <= `DCC_RST_RING_DIV;
            ref_r      <= 1'b0;
            irq_stat_r <= 4'h0;
            irq_mask_r <= 4'h0;
            done_d_r   <= '0;
            fail_d_r   <= '0;
            prdata_r   <= 32'h0;
            for (int k = 0; k < NUM_CONV; k++) begin
                mode_r[k] <= `DCC_RST_MODE;
                fsc_r[k]  <= `DCC_RST_FSC;
            end
        end else begin
            page_r     <= page_nxt;
            clk_div_r  <= clk_div_nxt;
            tune_r     <= tune_nxt;
            clk_pd_r   <= clk_pd_nxt;
            eng_en_r   <= eng_en_nxt;
            ring_r     <= ring_nxt;
            ref_r      <= ref_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            done_d_r   <= done;
            fail_d_r   <= fail;
            prdata_r   <= prdata_nxt;
            for (int k = 0; k < NUM_CONV; k++) begin
                mode_r[k] <= mode_nxt[k];
                fsc_r[k]  <= fsc_nxt[k];
            end
        end
    end

    // divider ratio: 8 shifted by the field
    always_comb begin
        case (ring_r)
            2'b00:   o_ring_osc_ratio = 7'h08;
            2'b01:   o_ring_osc_ratio = 7'h10;
            2'b10:   o_ring_osc_ratio = 7'h20;
            default: o_ring_osc_ratio = 7'h40;
        endcase
    end

    assign o_prdata                    = prdata_r;
    assign o_pready                    = i_psel && i_penable;
    // writes into the calibration range while busy are flagged, not blocked
    assign o_pslverr = wr_acc && busy && idx >= `DCC_IDX_CTRL
        && idx <= `DCC_IDX_TUNE;
    assign o_full_scale_code_conv0     = fsc_r[0];
    assign o_full_scale_code_conv1     = fsc_r[NUM_CONV-1];
    assign o_reference_coupling_select = ref_r;
    assign o_cal_clock_off             = clk_pd_r[1:0];
    assign o_irq                       = |(irq_stat_r & irq_mask_r);
endmodule : dcc_top

// ==== common/dcc_defs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH
`define DCC_IDX_PAGE        12'h008
`define DCC_IDX_CLK_DIV     12'h050
`define DCC_IDX_CTRL        12'h051
`define DCC_IDX_STAT        12'h052
`define DCC_IDX_FSC         12'h05a
`define DCC_IDX_TUNE        12'h061
`define DCC_IDX_CLK_PD      12'h081
`define DCC_IDX_RING        12'h083
`define DCC_IDX_SYSREF      12'h084
`define DCC_IDX_IRQ_STAT    12'h0f0
`define DCC_IDX_IRQ_MASK    12'h0f1
`define DCC_BIT_START       0
`define DCC_BIT_ENGINE_EN   7
`define DCC_BIT_ACTIVE      2
`define DCC_BIT_FAIL        1
`define DCC_BIT_DONE        0
`define DCC_BIT_REF_MODE    6
`define DCC_RST_MODE        2'h1
`define DCC_RST_ENGINE_EN   1'h1
`define DCC_RST_FSC         8'h28
`define DCC_RST_TUNE        8'h60
`define DCC_RST_CLK_DIV     8'h28
`define DCC_RST_RING_DIV    2'h2
`define DCC_RST_PAGE        8'h01
`define DCC_CAL_TIME_US     100
`define DCC_CLK_MHZ         20
`define DCC_CAL_CYCLES      (`DCC_CAL_TIME_US * `DCC_CLK_MHZ)
`define DCC_OPT_MODE        2'h1
`define DCC_OPT_CLK_DIV     4'ha
`define DCC_OPT_TUNE_MASK   8'h68
`endif

// ==== common/dcc_pkg.sv ====
// types shared by the calibration control block
package dcc_pkg;
    typedef enum logic [1:0] {
        DCC_IDLE = 2'b00,
        DCC_RUN  = 2'b01,
        DCC_END  = 2'b10
    } dcc_state_e;
    typedef logic [7:0] dcc_byte_t;
endpackage : dcc_pkg

// ==== src/dcc_cal_engine.sv ====
// one converter's calibration sequencer
`timescale 1ns/1ps
`include "dcc_defs.svh"
module dcc_cal_engine
    import dcc_pkg::*;
#(
    parameter int CAL_CYCLES = `DCC_CAL_CYCLES
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // control
    input  wire logic i_start,
    input  wire logic i_setup_ok,
    input  wire logic i_clk_off,
    // status
    output logic      o_active,
    output logic      o_fail,
    output logic      o_done
);
    dcc_state_e  state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic        fail_r, fail_nxt;
    logic        done_r, done_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        fail_nxt  = fail_r;
        done_nxt  = done_r;
        case (state_r)
            DCC_IDLE: begin
                if (i_start) begin
                    state_nxt = DCC_RUN;
                    cnt_nxt   = 32'h0;
                    fail_nxt  = 1'b0;
                    done_nxt  = 1'b0;
                end
            end
            DCC_RUN: begin
                // a gated calibration clock stalls the search
                if (!i_clk_off) begin
                    cnt_nxt = cnt_r + 32'h1;
                end
                if (cnt_r >= 32'(CAL_CYCLES - 1)) begin
                    state_nxt = DCC_END;
                end
            end
            DCC_END: begin
                state_nxt = DCC_IDLE;
                fail_nxt  = !i_setup_ok;
                done_nxt  = 1'b1;
            end
            default: begin
                state_nxt = DCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r <= DCC_IDLE;
            cnt_r   <= 32'h0;
            fail_r  <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            fail_r  <= fail_nxt;
            done_r  <= done_nxt;
        end
    end

    assign o_active = (state_r != DCC_IDLE);
    assign o_fail   = fail_r;
    assign o_done   = done_r;
endmodule : dcc_cal_engine

// ==== test/dcc_top_chk.sv ====
// port-level assertions for the calibration control block
`timescale 1ns/1ps
module dcc_top_chk
    import dcc_pkg::*;
#(
    parameter int NUM_CONV   = 2,
    parameter int CAL_CYCLES = 20
) (
    // clock and reset
    input wire logic               i_clk,
    input wire logic               i_sys_rst,
    // apb
    input wire logic               i_psel,
    input wire logic               i_penable,
    input wire logic               i_pwrite,
    input wire logic [11:0]        i_paddr,
    input wire logic [31:0]        i_pwdata,
    input wire logic [31:0]        o_prdata,
    input wire logic               o_pready,
    input wire logic               o_pslverr,
    // converter controls
    input wire dcc_pkg::dcc_byte_t o_full_scale_code_conv0,
    input wire dcc_pkg::dcc_byte_t o_full_scale_code_conv1,
    input wire logic [6:0]         o_ring_osc_ratio,
    input wire logic               o_reference_coupling_select,
    input wire logic [1:0]         o_cal_clock_off,
    input wire logic               o_irq
);
    logic [7:0] pg_r;
    logic [7:0] pg_nxt;
    wire        acc = i_psel && i_penable;
    // mirror of the page register so paged writes can be judged
    always_comb begin
        pg_nxt = pg_r;
        if (acc && i_pwrite && i_paddr == 12'h020) begin
            pg_nxt = i_pwdata[7:0];
        end
    end
    always_ff @(posedge i_clk) begin
        pg_r <= i_sys_rst ? 8'h01 : pg_nxt;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence wr_at(logic [11:0] a);
        acc && i_pwrite && i_paddr == a;
    endsequence
    pready_tie_a: assert property (o_pready == acc)
        else $error("pready does not follow access phase");
    reset_vals_a: assert property ($fell(i_sys_rst) |-> o_full_scale_code_conv0 == 8'h28 &&
        o_full_scale_code_conv1 == 8'h28 && o_ring_osc_ratio == 7'h20 &&
        !o_reference_coupling_select && o_cal_clock_off == 2'h0)
        else $error("outputs wrong after reset");
    fsc_paged_a: assert property ((wr_at(12'h168) ##0 pg_r[0]) |=>
        o_full_scale_code_conv0 == $past(i_pwdata[7:0]))
        else $error("paged full-scale write lost");
    fsc_other_a: assert property ((wr_at(12'h168) ##0 !pg_r[1]) |=>
        $stable(o_full_scale_code_conv1))
        else $error("unpaged full-scale copy changed");
    ring_ratio_a: assert property (wr_at(12'h20c) |=>
        o_ring_osc_ratio == (7'h08 << $past(i_pwdata[1:0])))
        else $error("ring divider ratio wrong");
    ref_mode_a: assert property (wr_at(12'h210) |=>
        o_reference_coupling_select == $past(i_pwdata[6]))
        else $error("reference coupling bit wrong");
    clk_off_a: assert property (wr_at(12'h204) |=> o_cal_clock_off == $past(i_pwdata[1:0]))
        else $error("clock off bits wrong");
    busy_err_a: assert property (o_pslverr |-> acc && i_pwrite &&
        i_paddr inside {[12'h144:12'h184]})
        else $error("error outside guarded range");
    rd_upper_a: assert property (acc && !i_pwrite |-> o_prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule : dcc_top_chk

// ==== test/tb_top.sv ====
// self-checking bench for the calibration control block
`timescale 1ns/1ps
`include "dcc_defs.svh"
module tb_top;
    import dcc_pkg::*;
    logic        i_clk = 1'h0, i_sys_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0;
    logic        i_pwrite = 1'h0, o_pready, o_pslverr, o_ref, o_irq, err_q;
    logic [11:0] i_paddr = 12'h0;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd_q;
    dcc_byte_t   o_fsc0, o_full_scale_current;
    logic [6:0]  o_ratio;
    logic [1:0]  o_clk_off;
    int          num_errors = 0, samples_checked = 0;
    dcc_top #(.NUM_CONV(2), .CAL_CYCLES(20)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_full_scale_code_conv0(o_fsc0), .o_full_scale_code_conv1(o_full_scale_current),
        .o_ring_osc_ratio(o_ratio), .o_reference_coupling_select(o_ref),
        .o_cal_clock_off(o_clk_off), .o_irq(o_irq));
    always #25 i_clk = ~i_clk;
    task finish_test;
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        int n;
        @(posedge i_clk);
        i_psel <= 1'h1;
        i_pwrite <= wr;
        i_paddr <= idx << 2;
        i_pwdata <= wd;
        @(posedge i_clk);
        i_penable <= 1'h1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'h1 && n < 50);
        if (n >= 50) begin
            chk(32'(o_pready), 32'h1);
            finish_test;
        end
        rd_q = o_prdata;
        err_q = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask : apb
    task rchk(input logic [11:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 32'h0);
        chk(rd_q, exp);
    endtask : rchk
    // poll status until the in-progress flag drops
    task cal_wait;
        int n;
        n = 0;
        do begin
            apb(1'h0, `DCC_IDX_STAT, 32'h0);
            n++;
        end while (rd_q[2] !== 1'h0 && n < 40);
        if (n >= 40) begin
            chk(rd_q, 32'h0);
            finish_test;
        end
    endtask : cal_wait
    task t_reset;
        chk({o_irq, o_clk_off, o_ref, o_ratio, o_full_scale_current, o_fsc0}, 32'h0_20_28_28);
        rchk(`DCC_IDX_CTRL, 32'h82);
        rchk(`DCC_IDX_STAT, 32'h0);
        rchk(`DCC_IDX_FSC, 32'h28);
        rchk(`DCC_IDX_TUNE, 32'h60);
        rchk(`DCC_IDX_RING, 32'h2);
        rchk(`DCC_IDX_SYSREF, 32'h0);
        apb(1'h1, 12'h0e0, 32'h5a);
        rchk(12'h0e0, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task t_fail;
        apb(1'h1, `DCC_IDX_CTRL, 32'h83);
        rchk(`DCC_IDX_STAT, 32'h4);
        apb(1'h1, `DCC_IDX_FSC, 32'h33);
        chk(32'(err_q), 32'h1);
        cal_wait;
        chk(rd_q, 32'h3);
        $display("t_fail done");
    endtask : t_fail
    task t_ok;
        apb(1'h1, `DCC_IDX_CLK_DIV, 32'h0a);
        apb(1'h1, `DCC_IDX_IRQ_MASK, 32'h0);
        apb(1'h1, `DCC_IDX_CTRL, 32'h83);
        apb(1'h1, `DCC_IDX_FSC, 32'h33);
        chk(32'(err_q), 32'h1);
        cal_wait;
        apb(1'h1, `DCC_IDX_FSC, 32'h33);
        chk(32'(err_q), 32'h0);
        rchk(`DCC_IDX_STAT, 32'h1);
        rchk(`DCC_IDX_IRQ_STAT, 32'h5);
        @(negedge i_clk);
        chk(32'(o_irq), 32'h0);
        apb(1'h1, `DCC_IDX_IRQ_MASK, 32'h1);
        @(negedge i_clk);
        chk(32'(o_irq), 32'h1);
        apb(1'h1, `DCC_IDX_IRQ_STAT, 32'h1);
        @(negedge i_clk);
        chk(32'(o_irq), 32'h0);
        rchk(`DCC_IDX_IRQ_STAT, 32'h4);
        $display("t_ok done");
    endtask : t_ok
    task t_page;
        apb(1'h1, `DCC_IDX_PAGE, 32'h2);
        apb(1'h1, `DCC_IDX_FSC, 32'h5c);
        @(negedge i_clk);
        chk({16'h0, o_full_scale_current, o_fsc0}, 32'h5c33);
        apb(1'h1, `DCC_IDX_CTRL, 32'h83);
        rchk(`DCC_IDX_STAT, 32'h4);
        apb(1'h1, `DCC_IDX_PAGE, 32'h1);
        rchk(`DCC_IDX_STAT, 32'h1);
        apb(1'h1, `DCC_IDX_PAGE, 32'h2);
        cal_wait;
        chk(rd_q, 32'h1);
        apb(1'h1, `DCC_IDX_CLK_PD, 32'h3);
        @(negedge i_clk);
        chk(32'(o_clk_off), 32'h3);
        $display("t_page done");
    endtask : t_page
    task t_ring;
        for (int k = 0; k < 4; k++) begin
            apb(1'h1, `DCC_IDX_RING, 32'(k));
            @(negedge i_clk);
            chk(32'(o_ratio), 32'(8 << k));
            rchk(`DCC_IDX_RING, 32'(k));
        end
        apb(1'h1, `DCC_IDX_SYSREF, 32'h40);
        @(negedge i_clk);
        chk(32'(o_ref), 32'h1);
        rchk(`DCC_IDX_SYSREF, 32'h40);
        $display("t_ring done");
    endtask : t_ring
    initial begin
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'h0;
        t_reset;
        t_fail;
        t_ok;
        t_page;
        t_ring;
        finish_test;
    end
endmodule : tb_top
bind dcc_top dcc_top_chk #(.NUM_CONV(NUM_CONV), .CAL_CYCLES(CAL_CYCLES)) i_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_full_scale_code_conv0(o_full_scale_code_conv0),
    .o_full_scale_code_conv1(o_full_scale_code_conv1), .o_ring_osc_ratio(o_ring_osc_ratio),
    .o_reference_coupling_select(o_reference_coupling_select),
    .o_cal_clock_off(o_cal_clock_off), .o_irq(o_irq));
